// File: wake_cfg.svh
// Constants for the wake-up receiver configuration bank: offsets, fields, defaults, timing.
`ifndef WAKE_CFG_SVH
`define WAKE_CFG_SVH

// ----------------------------------------
// Register indices (serial address field)
// ----------------------------------------
`define IDX_CHAN_MODE 0
`define IDX_CORR_AGC 1
`define IDX_TOL_SLICER 2
`define IDX_SLICER_ENV 3
`define IDX_DUTY_DAMP 4
`define IDX_PAT_SECOND 5
`define IDX_PAT_FIRST 6
`define IDX_TIMEOUT_RATE 7
`define IDX_ART_WAKE 8
`define IDX_RESERVED 9
`define IDX_STRENGTH1 10
`define IDX_STRENGTH2 11
`define IDX_STRENGTH3 12
`define IDX_FALSE_WAKE 13
`define NUM_CFG_REGS 10

// ----------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------
`define DEF_CHAN_MODE 8'h0E
`define DEF_CORR_AGC 8'h23
`define DEF_TOL_SLICER 8'h00
`define DEF_SLICER_ENV 8'h20
`define DEF_DUTY_DAMP 8'h10
`define DEF_PAT_SECOND 8'h69
`define DEF_PAT_FIRST 8'h96
`define DEF_TIMEOUT_RATE 8'h0B
`define DEF_ART_WAKE 8'h00
`define DEF_RESERVED 8'h00
`define MASK_CHAN_MODE 8'h3F
`define MASK_CORR_AGC 8'hF7
`define MASK_TOL_SLICER 8'hE3
`define MASK_ART_WAKE 8'h07
`define MASK_FULL 8'hFF
`define MASK_NONE 8'h00

// ----------------------------------------
// Serial command codes
// ----------------------------------------
`define MODE_WRITE 2'h0
`define MODE_READ 2'h1
`define MODE_DIRECT 2'h3
`define CMD_CLEAR_WAKE 6'h00
`define CMD_RESET_STRENGTH 6'h01
`define CMD_TRIM_OSC 6'h02
`define CMD_CLEAR_FALSE 6'h03
`define CMD_PRESET_DEFAULT 6'h04

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define SLOT_TIME_NS 1000000
`define SLOT_CYCLES (`SLOT_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: wake_cfg_pkg.sv
// Types shared by the wake-up receiver configuration bank and its users.
package wake_cfg_pkg;

	// Settings fanned out to the analog front end, correlator and timers
	typedef struct packed {
		logic onoff_en;
		logic scan_listen_en;
		logic chan1_en;
		logic chan2_en;
		logic chan3_en;
		logic power_down_ctrl;
		logic slicer_abs_ref;
		logic gain_first_burst_only;
		logic gain_bidirectional;
		logic antenna_damper_en;
		logic double_pattern_en;
		logic correlation_en;
		logic xtal_osc_en;
		logic slicer_threshold_reduce;
		logic [1:0] pattern_tolerance;
		logic [1:0] stage_wake_tolerance;
		logic slicer_small_hysteresis;
		logic slicer_positive_edge_hyst;
		logic [2:0] slicer_time_const;
		logic [2:0] envelope_time_const;
		logic [1:0] off_time_sel;
		logic [1:0] damping_resistor_sel;
		logic [3:0] gain_reduction;
		logic [7:0] pattern_first_byte;
		logic [7:0] pattern_second_byte;
		logic [2:0] timeout_sel;
		logic [4:0] half_bit_rate;
		logic [2:0] artificial_wake_sel;
	} cfg_t;

	// One-cycle strobes for direct commands handled outside the bank
	typedef struct packed {
		logic clear_wake;
		logic reset_strength;
		logic trim_osc;
	} cmd_pulse_t;

	// Serial frame phase
	typedef enum logic [1:0] {
		PH_HEAD,
		PH_WDATA,
		PH_RDATA,
		PH_SKIP
	} frame_phase_t;

	// On/off listening phase
	typedef enum logic {
		LS_ON,
		LS_OFF
	} listen_state_t;

endpackage : wake_cfg_pkg

// File: wakeup_receiver_config_bank.sv
// Configuration and status register bank of a three-channel wake-up receiver.
//
// Contract
// - On/off listening select bit, reset 0
// - Pattern correlation enable, reset 1
// - Crystal oscillator enable, reset 1
// - Doubled pattern select, reset 0
// - Gain moves up and down, reset 1
// - Gain limited to first burst
// - Antenna damper enable, reset 0
// - Absolute slicer reference select
// - Slicer threshold reduction, reset 0
// - Pattern tolerance field, reset 00
// - Frequency tolerance field, reset 00
// - Off-time code gives 1, 2, 4, 8 ms
// - Pattern bytes reset to 96h and 69h
// - Receive timeout field, reset 000
// - Half-bit rate field, reset 01011
// - Slicer time constant field, reset 100
// - Envelope time constant field, reset 000
// - Mode code: write, read, direct, 10 illegal
// - Six address bits, then eight data bits
// - Clear-false command zeroes false wake counter
// - Preset-default command reloads all configuration defaults
`include "wake_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wakeup_receiver_config_bank #(
	parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic spi_cs,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic [4:0] signal_strength_ch1,
	input wire logic [4:0] signal_strength_ch2,
	input wire logic [4:0] signal_strength_ch3,
	input wire logic false_wake_evt,
	input wire logic carrier_det,
	output var wake_cfg_pkg::cfg_t cfg,
	output var wake_cfg_pkg::cmd_pulse_t cmd,
	output logic [2:0] chan_power,
	output logic listen_on
);
	import wake_cfg_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] pin_meta_q; // First stage, read only by second stage
	logic [2:0] pin_sync_q; // {cs, sclk, sdi} in ref_clk domain
	logic sclk_prev_q; // Last synced sclk, for edge detect
	wire cs_s = pin_sync_q[2];
	wire sclk_s = pin_sync_q[1];
	wire sdi_s = pin_sync_q[0];

	// Two flops per pin; the serial clock is far slower than ref_clk
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
			sclk_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= {spi_cs, spi_sclk, spi_sdi};
			pin_sync_q <= pin_meta_q;
			sclk_prev_q <= pin_sync_q[1];
		end
	end

	// Data is sampled on the falling serial clock edge while selected
	wire sclk_fall = cs_s & sclk_prev_q & ~sclk_s;

	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	frame_phase_t phase_q; // Where in the frame we are
	logic [2:0] bit_cnt_q; // Bit within current byte
	logic [7:0] shift_q; // Incoming byte
	logic [5:0] addr_q; // Current register address
	logic [7:0] rd_shift_q; // Outgoing byte, MSB on the pin

	// Byte assembled with the bit arriving now
	wire [7:0] shift_in = {shift_q[6:0], sdi_s};
	wire byte_done = sclk_fall & (bit_cnt_q == 3'h7);

	// Header decode: mode code, then six address or command bits
	wire [1:0] head_mode = shift_in[7:6];
	wire [5:0] head_addr = shift_in[5:0];
	wire head_done = byte_done & (phase_q == PH_HEAD);
	wire head_wr = head_done & (head_mode == `MODE_WRITE);
	wire head_rd = head_done & (head_mode == `MODE_READ);
	wire head_dir = head_done & (head_mode == `MODE_DIRECT);

	// Direct command strobes, same cycle as the header completes
	wire dir_clear_false = head_dir & (head_addr == `CMD_CLEAR_FALSE);
	wire dir_preset = head_dir & (head_addr == `CMD_PRESET_DEFAULT);

	// Write strobe for a completed data byte
	wire wr_fire = byte_done & (phase_q == PH_WDATA);

	// Read address: header address first, then auto-increment
	wire [5:0] rd_addr = (phase_q == PH_HEAD) ? head_addr : 6'(addr_q + 6'h01);

	// Serial pins are sampled on ref_clk, so
	// each serial clock phase must last at
	// least three ref_clk cycles.
	// A header byte carries the mode code and
	// six address or command bits; data bytes
	// follow until select drops.
	// Bytes after the first go to the next
	// address, for writes and reads alike.
	// The spare mode code is dropped together
	// with everything after it.
	// Deselecting ends the frame and throws away
	// a partial byte, so a cut write changes
	// nothing.
	// Limitation: the header address is not
	// range checked; unmapped reads give zero
	// and unmapped writes are lost.
	// Preset keeps the false wake count so the
	// host can still read it afterwards.

	// Frame sequencer: header byte, then data bytes until select drops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_q <= PH_HEAD;
			bit_cnt_q <= 3'h0;
			shift_q <= 8'h00;
			addr_q <= 6'h00;
		end else if (!cs_s) begin
			// Deselect ends any command, complete or not
			phase_q <= PH_HEAD;
			bit_cnt_q <= 3'h0;
		end else if (sclk_fall) begin
			shift_q <= shift_in;
			bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
			if (head_wr) begin
				phase_q <= PH_WDATA;
				addr_q <= head_addr;
			end else if (head_rd) begin
				phase_q <= PH_RDATA;
				addr_q <= head_addr;
			end else if (head_done) begin
				// Direct commands carry no data; the illegal code is dropped
				phase_q <= PH_SKIP;
			end else if (byte_done && phase_q != PH_SKIP) begin
				// Consecutive bytes go to consecutive addresses
				addr_q <= 6'(addr_q + 6'h01);
			end
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	localparam logic [7:0] DEF_VAL [`NUM_CFG_REGS] = '{
		`DEF_CHAN_MODE, `DEF_CORR_AGC, `DEF_TOL_SLICER, `DEF_SLICER_ENV, `DEF_DUTY_DAMP,
		`DEF_PAT_SECOND, `DEF_PAT_FIRST, `DEF_TIMEOUT_RATE, `DEF_ART_WAKE, `DEF_RESERVED};
	localparam logic [7:0] WR_MASK [`NUM_CFG_REGS] = '{
		`MASK_CHAN_MODE, `MASK_CORR_AGC, `MASK_TOL_SLICER, `MASK_FULL, `MASK_FULL,
		`MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_ART_WAKE, `MASK_NONE};

	logic [7:0] cfg_q [`NUM_CFG_REGS]; // Writable register contents

	// One register per entry; unused bits never store a one
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CFG_REGS; gi++) begin : g_cfg
			wire hit = wr_fire & (addr_q == 6'(gi));
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					cfg_q[gi] <= DEF_VAL[gi];
				end else if (dir_preset) begin
					cfg_q[gi] <= DEF_VAL[gi];
				end else if (hit) begin
					cfg_q[gi] <= shift_in & WR_MASK[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// False wake-up counter
	// ----------------------------------------
	logic [7:0] false_wake_q; // Saturating count of false wake-ups

	// A new event in the clearing cycle is kept, so the count becomes one
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			false_wake_q <= 8'h00;
		end else if (dir_clear_false) begin
			false_wake_q <= false_wake_evt ? 8'h01 : 8'h00;
		end else if (false_wake_evt && false_wake_q != 8'hFF) begin
			false_wake_q <= 8'(false_wake_q + 8'h01);
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Strength values are five bits; upper bits read zero
	wire [7:0] rd_strength1 = {3'h0, signal_strength_ch1};
	wire [7:0] rd_strength2 = {3'h0, signal_strength_ch2};
	wire [7:0] rd_strength3 = {3'h0, signal_strength_ch3};
	wire rd_is_cfg = rd_addr < 6'(`NUM_CFG_REGS);
	wire [7:0] rd_status =
		(rd_addr == 6'(`IDX_STRENGTH1)) ? rd_strength1 :
		(rd_addr == 6'(`IDX_STRENGTH2)) ? rd_strength2 :
		(rd_addr == 6'(`IDX_STRENGTH3)) ? rd_strength3 :
		(rd_addr == 6'(`IDX_FALSE_WAKE)) ? false_wake_q :
		8'h00;
	wire [7:0] rd_data = rd_is_cfg ? cfg_q[rd_addr[3:0]] : rd_status;
	wire rd_load = head_rd | (byte_done & (phase_q == PH_RDATA));

	// Outgoing byte: loaded at each byte boundary, shifted on falling edges
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_shift_q <= 8'h00;
		end else if (rd_load) begin
			rd_shift_q <= rd_data;
		end else if (sclk_fall && phase_q == PH_RDATA) begin
			rd_shift_q <= {rd_shift_q[6:0], 1'b0};
		end
	end

	// Pin drives only while selected so the line can be shared
	assign spi_sdo = rd_shift_q[7];
	assign spi_sdo_oe = cs_s;

	// ----------------------------------------
	// Direct command strobes
	// ----------------------------------------
	logic [2:0] cmd_q; // {clear_wake, reset_strength, trim_osc}

	// Registered one-cycle pulses toward the wake and oscillator logic
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_q <= 3'h0;
		end else begin
			cmd_q[2] <= head_dir & (head_addr == `CMD_CLEAR_WAKE);
			cmd_q[1] <= head_dir & (head_addr == `CMD_RESET_STRENGTH);
			cmd_q[0] <= head_dir & (head_addr == `CMD_TRIM_OSC);
		end
	end

	assign cmd.clear_wake = cmd_q[2];
	assign cmd.reset_strength = cmd_q[1];
	assign cmd.trim_osc = cmd_q[0];

	// ----------------------------------------
	// Field fan-out
	// ----------------------------------------
	wire [7:0] r_chan = cfg_q[`IDX_CHAN_MODE];
	wire [7:0] r_corr = cfg_q[`IDX_CORR_AGC];
	wire [7:0] r_tol = cfg_q[`IDX_TOL_SLICER];
	wire [7:0] r_slc = cfg_q[`IDX_SLICER_ENV];
	wire [7:0] r_duty = cfg_q[`IDX_DUTY_DAMP];
	wire [7:0] r_tmo = cfg_q[`IDX_TIMEOUT_RATE];

	assign cfg.onoff_en = r_chan[5];
	assign cfg.scan_listen_en = r_chan[4];
	assign cfg.chan2_en = r_chan[3];
	assign cfg.chan3_en = r_chan[2];
	assign cfg.chan1_en = r_chan[1];
	assign cfg.power_down_ctrl = r_chan[0];
	assign cfg.slicer_abs_ref = r_corr[7];
	assign cfg.gain_first_burst_only = r_corr[6];
	assign cfg.gain_bidirectional = r_corr[5];
	assign cfg.antenna_damper_en = r_corr[4];
	assign cfg.double_pattern_en = r_corr[2];
	assign cfg.correlation_en = r_corr[1];
	assign cfg.xtal_osc_en = r_corr[0];
	assign cfg.slicer_threshold_reduce = r_tol[7];
	assign cfg.pattern_tolerance = r_tol[6:5];
	assign cfg.stage_wake_tolerance = r_tol[1:0];
	assign cfg.slicer_small_hysteresis = r_slc[7];
	assign cfg.slicer_positive_edge_hyst = r_slc[6];
	assign cfg.slicer_time_const = r_slc[5:3];
	assign cfg.envelope_time_const = r_slc[2:0];
	assign cfg.off_time_sel = r_duty[7:6];
	assign cfg.damping_resistor_sel = r_duty[5:4];
	assign cfg.gain_reduction = r_duty[3:0];
	assign cfg.pattern_second_byte = cfg_q[`IDX_PAT_SECOND];
	assign cfg.pattern_first_byte = cfg_q[`IDX_PAT_FIRST];
	assign cfg.timeout_sel = r_tmo[7:5];
	assign cfg.half_bit_rate = r_tmo[4:0];
	assign cfg.artificial_wake_sel = cfg_q[`IDX_ART_WAKE][2:0];

	// ----------------------------------------
	// Listening time slots
	// ----------------------------------------
	localparam logic [16:0] SLOT_LAST = 17'(SLOT_CYCLES - 1);
	logic [16:0] slot_cnt_q; // Cycles left in current 1 ms slot
	wire slot_tick = (slot_cnt_q == 17'h0);

	// Free-running slot divider, one-cycle tick per slot
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			slot_cnt_q <= SLOT_LAST;
		end else if (slot_tick) begin
			slot_cnt_q <= SLOT_LAST;
		end else begin
			slot_cnt_q <= 17'(slot_cnt_q - 17'h1);
		end
	end

	// Off duration in slots: 1, 2, 4 or 8
	wire [3:0] off_slots = 4'(4'h1 << cfg.off_time_sel);
	listen_state_t listen_q; // On or off phase of on/off mode
	logic [3:0] off_cnt_q; // Off slots still to run

	// One slot on, then the programmed off time; plain listening stays on
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			listen_q <= LS_ON;
			off_cnt_q <= 4'h0;
		end else if (!cfg.onoff_en) begin
			listen_q <= LS_ON;
		end else if (slot_tick) begin
			unique case (listen_q)
				LS_ON: begin
					listen_q <= LS_OFF;
					off_cnt_q <= 4'(off_slots - 4'h1);
				end
				LS_OFF: begin
					if (off_cnt_q == 4'h0) begin
						listen_q <= LS_ON;
					end else begin
						off_cnt_q <= 4'(off_cnt_q - 4'h1);
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Scan rotation: channel 1, then 3, then 2
	// ----------------------------------------
	logic [1:0] scan_idx_q; // Rotation position
	wire carrier_hold = carrier_det;

	// Rotation freezes while a carrier is present so all can evaluate
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scan_idx_q <= 2'h0;
		end else if (!cfg.scan_listen_en) begin
			scan_idx_q <= 2'h0;
		end else if (slot_tick && !carrier_hold) begin
			scan_idx_q <= (scan_idx_q == 2'h2) ? 2'h0 : 2'(scan_idx_q + 2'h1);
		end
	end

	wire [2:0] scan_sel =
		(scan_idx_q == 2'h0) ? 3'h1 :
		(scan_idx_q == 2'h1) ? 3'h4 :
		3'h2;
	wire [2:0] chan_en = {cfg.chan3_en, cfg.chan2_en, cfg.chan1_en};
	wire scan_gate = cfg.scan_listen_en & ~carrier_hold;
	wire [2:0] chan_pick = scan_gate ? (chan_en & scan_sel) : chan_en;

	// Power-down overrides every listening mode
	assign listen_on = ~cfg.power_down_ctrl & (listen_q == LS_ON);
	assign chan_power = chan_pick & {3{listen_on}};

endmodule : wakeup_receiver_config_bank

`default_nettype wire

// File: wake_cfg_bank_assertions.sv
// Port checker for the wake-up receiver configuration bank.
`timescale 1ns/1ps
`default_nettype none

module wake_cfg_bank_assertions #(
	parameter int SLOT_CYCLES = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic spi_cs,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe,
	input wire logic [4:0] signal_strength_ch1,
	input wire logic [4:0] signal_strength_ch2,
	input wire logic [4:0] signal_strength_ch3,
	input wire logic false_wake_evt,
	input wire logic carrier_det,
	input wire wake_cfg_pkg::cfg_t cfg,
	input wire wake_cfg_pkg::cmd_pulse_t cmd,
	input wire logic [2:0] chan_power,
	input wire logic listen_on
);
	import wake_cfg_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Off-phase length; counts only while on/off listening is live
	logic [7:0] off_run_q;
	logic [7:0] off_run_d;
	assign off_run_d = (cfg.onoff_en && !cfg.power_down_ctrl && !listen_on) ? off_run_q + 8'h01 : 8'h00;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			off_run_q <= 8'h00;
		end else begin
			off_run_q <= off_run_d;
		end
	end
	sequence reset_left;
		$fell(rst);
	endsequence
	// Long enough for the chip-select synchroniser to settle
	sequence cs_idle;
		!spi_cs [*5];
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_onoff_default: assert property (reset_left |-> !cfg.onoff_en)
		else $error("on/off listening set after reset");
	a_corr_default: assert property (reset_left |-> cfg.correlation_en)
		else $error("correlation off after reset");
	a_osc_default: assert property (reset_left |-> cfg.xtal_osc_en)
		else $error("oscillator off after reset");
	a_agc_default: assert property (reset_left |-> {cfg.slicer_abs_ref, cfg.gain_first_burst_only,
		cfg.gain_bidirectional, cfg.antenna_damper_en, cfg.double_pattern_en} == 5'h04)
		else $error("gain and slicer bits wrong after reset");
	a_tol_default: assert property (reset_left |-> {cfg.slicer_threshold_reduce, cfg.pattern_tolerance,
		cfg.stage_wake_tolerance} == 5'h00 && cfg.off_time_sel == 2'h0)
		else $error("tolerance or off time wrong after reset");
	a_pattern_default: assert property (reset_left |-> {cfg.pattern_first_byte, cfg.pattern_second_byte} == 16'h9669)
		else $error("pattern bytes wrong after reset");
	a_rate_default: assert property (reset_left |-> {cfg.timeout_sel, cfg.half_bit_rate} == 8'h0B)
		else $error("timeout or bit rate wrong after reset");
	a_slicer_default: assert property (reset_left |-> {cfg.slicer_time_const, cfg.envelope_time_const} == 6'h20)
		else $error("slicer constants wrong after reset");
	a_listen_steady: assert property ((!cfg.onoff_en && !cfg.power_down_ctrl) [*2] |-> listen_on)
		else $error("listening paused with on/off mode off");
	a_off_ceiling: assert property (off_run_q <= (SLOT_CYCLES << cfg.off_time_sel) + 1)
		else $error("off phase too long");
	a_off_floor: assert property ($rose(listen_on) && cfg.onoff_en && off_run_q != 8'h00
		|-> off_run_q >= (SLOT_CYCLES << cfg.off_time_sel) - 1)
		else $error("off phase too short");
	a_sdo_release: assert property (cs_idle |-> !spi_sdo_oe)
		else $error("data out driven while deselected");
	a_cfg_frozen: assert property (cs_idle |-> $stable(cfg))
		else $error("configuration moved without a command");
endmodule : wake_cfg_bank_assertions

bind wakeup_receiver_config_bank wake_cfg_bank_assertions #(.SLOT_CYCLES(SLOT_CYCLES)) i_chk (
	.ref_clk(ref_clk), .rst(rst), .spi_cs(spi_cs), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
	.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .signal_strength_ch1(signal_strength_ch1),
	.signal_strength_ch2(signal_strength_ch2), .signal_strength_ch3(signal_strength_ch3),
	.false_wake_evt(false_wake_evt), .carrier_det(carrier_det), .cfg(cfg), .cmd(cmd),
	.chan_power(chan_power), .listen_on(listen_on));
`default_nettype wire

// File: spi_host_model.sv
// Microcontroller model driving the four-wire serial programming port.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	output logic spi_cs,
	output logic spi_sclk,
	output logic spi_sdi,
	input wire logic ref_clk,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe
);
	// Serial clock half period; above the 3-cycle floor of the synchroniser
	localparam int HALF = 4;

	// Pulled-down lines rest low while idle
	initial begin
		spi_cs = 1'b0;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
	end

	// One byte, MSB first; data out is taken just before the sampling fall
	task automatic shift8(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			@(negedge ref_clk);
			spi_sdi = w[i];
			spi_sclk = 1'b1;
			repeat (HALF) @(negedge ref_clk);
			r = {r[6:0], spi_sdo_oe ? spi_sdo : ~spi_sdo};
			spi_sclk = 1'b0;
			repeat (HALF - 1) @(negedge ref_clk);
		end
	endtask : shift8

	task automatic cs_up();
		@(negedge ref_clk);
		spi_cs = 1'b1;
		repeat (HALF) @(negedge ref_clk);
	endtask : cs_up

	// Deselect returns data in to its pull-down level
	task automatic cs_down();
		repeat (HALF) @(negedge ref_clk);
		spi_cs = 1'b0;
		spi_sdi = 1'b0;
		repeat (6) @(negedge ref_clk);
	endtask : cs_down

	// Header byte (mode and address) then one data byte
	task automatic frame16(input logic [15:0] w, output logic [7:0] r);
		logic [7:0] hdr;
		cs_up();
		shift8(w[15:8], hdr);
		shift8(w[7:0], r);
		cs_down();
	endtask : frame16

	// Direct command: header byte alone
	task automatic frame8(input logic [7:0] w);
		logic [7:0] r;
		cs_up();
		shift8(w, r);
		cs_down();
	endtask : frame8
endmodule : spi_host_model
`default_nettype wire

// File: wakeup_receiver_config_bank_test.sv
// Self-checking testbench for the wake-up receiver configuration bank.
`timescale 1ns/1ps
`default_nettype none

module wakeup_receiver_config_bank_test;
	import wake_cfg_pkg::*;
	// Short slot keeps off phases to a few dozen cycles
	localparam int SLOT = 8;
	localparam int LIMIT = 60000;
	logic ref_clk;
	logic rst;
	logic spi_cs, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
	logic [4:0] str1, str2, str3;
	logic false_wake_evt;
	logic carrier_det;
	cfg_t cfg;
	cmd_pulse_t cmd;
	logic [2:0] chan_power;
	logic listen_on;
	int num_errors;
	int tests_run;
	int cyc;
	logic [7:0] pulses; // Strobe tally
	// Reset values and writable-bit masks of registers 0..9
	logic [7:0] defs [10] = '{8'h0E, 8'h23, 8'h00, 8'h20, 8'h10, 8'h69, 8'h96, 8'h0B, 8'h00, 8'h00};
	logic [7:0] msks [10] = '{8'h3F, 8'hF7, 8'hE3, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00};

	wakeup_receiver_config_bank #(.SLOT_CYCLES(SLOT)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.spi_cs(spi_cs), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
		.signal_strength_ch1(str1), .signal_strength_ch2(str2), .signal_strength_ch3(str3),
		.false_wake_evt(false_wake_evt), .carrier_det(carrier_det), .cfg(cfg), .cmd(cmd),
		.chan_power(chan_power), .listen_on(listen_on));
	spi_host_model i_host (.spi_cs(spi_cs), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .ref_clk(ref_clk),
		.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Hang guard
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			num_errors++;
			tally_and_finish();
		end
	end

	// Strobe tally: clear_wake counts 16, reset_strength 4, trim_osc 1
	always @(posedge ref_clk) begin
		pulses <= pulses + {3'h0, cmd.clear_wake, 1'b0, cmd.reset_strength, 1'b0, cmd.trim_osc};
	end

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check8

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] x;
		i_host.frame16({2'b00, a, d}, x);
	endtask : wr

	task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host.frame16({2'b01, a, 8'h00}, d);
		check8(d, exp);
	endtask : chk_reg

	task automatic t_defaults();
		for (int i = 0; i < 10; i++) begin
			chk_reg(6'(i), defs[i]);
		end
		$display("test defaults done");
	endtask : t_defaults

	// All ones everywhere: reserved bits must stay zero, fields must reach cfg
	task automatic t_write_all();
		for (int i = 0; i < 10; i++) begin
			wr(6'(i), 8'hFF);
			chk_reg(6'(i), msks[i]);
		end
		check8({cfg.slicer_abs_ref, cfg.gain_first_burst_only, cfg.gain_bidirectional, cfg.antenna_damper_en, 1'b0,
			cfg.double_pattern_en, cfg.correlation_en, cfg.xtal_osc_en}, 8'hF7);
		check8({cfg.slicer_threshold_reduce, cfg.pattern_tolerance, 3'h0, cfg.stage_wake_tolerance}, 8'hE3);
		check8({cfg.timeout_sel, cfg.half_bit_rate}, 8'hFF);
		check8({cfg.slicer_small_hysteresis, cfg.slicer_positive_edge_hyst, cfg.slicer_time_const,
			cfg.envelope_time_const}, 8'hFF);
		check8(cfg.pattern_first_byte & cfg.pattern_second_byte, 8'hFF);
		check8({2'h0, cfg.onoff_en, cfg.scan_listen_en, cfg.chan2_en, cfg.chan3_en, cfg.chan1_en,
			cfg.power_down_ctrl}, 8'h3F);
		check8({cfg.off_time_sel, cfg.damping_resistor_sel, cfg.gain_reduction}, 8'hFF);
		check8({5'h0, cfg.artificial_wake_sel}, 8'h07);
		$display("test write all done");
	endtask : t_write_all

	// Status registers refuse writes; counter counts and clears
	task automatic t_status();
		str1 = 5'h15;
		str2 = 5'h0A;
		str3 = 5'h1F;
		for (int i = 10; i < 14; i++) begin
			wr(6'(i), 8'hFF);
		end
		chk_reg(6'd10, 8'h15);
		chk_reg(6'd11, 8'h0A);
		chk_reg(6'd12, 8'h1F);
		repeat (3) begin
			@(negedge ref_clk);
			false_wake_evt = 1'b1;
			@(negedge ref_clk);
			false_wake_evt = 1'b0;
		end
		chk_reg(6'd13, 8'h03);
		i_host.frame8(8'hC3);
		chk_reg(6'd13, 8'h00);
		chk_reg(6'd40, 8'h00);
		$display("test status done");
	endtask : t_status

	// Spare mode code must not write
	task automatic t_mode_spare();
		logic [7:0] x;
		i_host.frame16({2'b10, 6'd6, 8'h5A}, x);
		chk_reg(6'd6, 8'h96);
		$display("test spare mode done");
	endtask : t_mode_spare

	// Each side-effect command gives exactly one pulse on its own strobe
	task automatic t_cmds();
		pulses = 8'h00;
		for (int c = 0; c < 3; c++) begin
			i_host.frame8({2'b11, 6'(c)});
		end
		check8(pulses, 8'h15);
		$display("test direct strobes done");
	endtask : t_cmds

	// Scan rotation 1, 3, 2 per slot; a carrier powers every enabled channel
	task automatic t_scan();
		int n;
		wr(6'd0, 8'h1E);
		carrier_det = 1'b1;
		@(negedge ref_clk);
		check8(8'(chan_power), 8'h07);
		carrier_det = 1'b0;
		n = 0;
		while (chan_power !== 3'h1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		while (chan_power === 3'h1 && n < 80) begin
			@(negedge ref_clk);
			n++;
		end
		check8(8'(chan_power), 8'h04);
		repeat (SLOT) @(negedge ref_clk);
		check8(8'(chan_power), 8'h02);
		repeat (SLOT) @(negedge ref_clk);
		check8(8'(chan_power), 8'h01);
		$display("test scan done");
	endtask : t_scan

	// Every off-time code, measured on a full off phase
	task automatic t_offtime();
		int n;
		for (int s = 0; s < 4; s++) begin
			wr(6'd0, 8'h0E);
			wr(6'd4, {2'(s), 6'h10});
			wr(6'd0, 8'h2E);
			n = 0;
			while (listen_on !== 1'b0 && n < 300) begin
				@(negedge ref_clk);
				n++;
			end
			while (listen_on !== 1'b1 && n < 600) begin
				@(negedge ref_clk);
				n++;
			end
			while (listen_on !== 1'b0 && n < 900) begin
				@(negedge ref_clk);
				n++;
			end
			n = 0;
			while (listen_on === 1'b0 && n < 300) begin
				@(negedge ref_clk);
				n++;
			end
			check8(8'(n), 8'(SLOT << s));
		end
		$display("test off time done");
	endtask : t_offtime

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		rst = 1'b1;
		str1 = 5'h00;
		str2 = 5'h00;
		str3 = 5'h00;
		false_wake_evt = 1'b0;
		carrier_det = 1'b0;
		num_errors = 0;
		tests_run = 0;
		cyc = 0;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		t_defaults();
		t_write_all();
		t_status();
		i_host.frame8(8'hC4);
		t_defaults();
		t_mode_spare();
		t_cmds();
		t_scan();
		t_offtime();
		tally_and_finish();
	end
endmodule : wakeup_receiver_config_bank_test
`default_nettype wire
